// *** hw/sbr_params.svh ***
`ifndef SBR_PARAMS_SVH
`define SBR_PARAMS_SVH
`define SBR_ADDR_STATUS 8'h00
`define SBR_ADDR_MASK 8'h01
`define SBR_ADDR_MODE 8'h3B
`define SBR_ADDR_GAIN 8'h44
`define SBR_ADDR_ROUTING 8'h45
`define SBR_ADDR_CHGAIN 8'h55
`define SBR_RST_MODE 16'h22FC
`define SBR_RST_GAIN 16'h1C38
`define SBR_RST_ROUTING 16'hADA5
`define SBR_RST_MASK 16'h00FF
`define SBR_RST_CHGAIN 16'h0000
`define SBR_ROUTE_FULL 16'hADA5
`define SBR_ROUTE_TIA_ADC 16'hB065
`define SBR_BIT_CLEAR 15
`define SBR_BIT_IND_EN 6
`define SBR_BIT_B_FLAG 6
`define SBR_BIT_A_FLAG 5
`define SBR_BIT_SPARE 7
`define SBR_BIT_B_MASK 6
`define SBR_BIT_A_MASK 5
`endif

// *** hw/sbr_pkg.sv ***
package sbr_pkg;
	// Transimpedance gain selection, one-hot per channel.
	typedef enum logic [3:0]
	{
		SBR_GAIN_200K = 4'h1,
		SBR_GAIN_100K = 4'h2,
		SBR_GAIN_50K = 4'h4,
		SBR_GAIN_25K = 4'h8
	} sbr_gain_t;
	// Front-end routing modes decoded from the routing word.
	typedef enum logic [1:0]
	{
		SBR_ROUTE_RSVD = 2'h0,
		SBR_ROUTE_FULL_PATH = 2'h1,
		SBR_ROUTE_TIA_CONV = 2'h2
	} sbr_route_t;
endpackage

// *** hw/sbr_regs.sv ***
`timescale 1ns/1ps
`include "sbr_params.svh"

// Functional notes
// - Override bit 6 set: ch1 from gain bits [1:0], ch2-4 from chgain bits [7:6], [9:8], [11:10].
// - Override clear: gain bits [1:0] apply to all four channels.
// - Gain code 0..3 selects 200k, 100k, 50k, 25k ohm.
// - Routing resets to 0xADA5 full path; 0xB065 TIA-converter; others reserved.
// - Status bits [15:8] report FIFO bytes available.
// - With access enable set, writing 1 to status bit 15 empties FIFO.
// - Slot B event sets status bit 6, slot A event sets bit 5.
// - Writing 1 to a slot flag clears it.
// - Writing 0 to a slot flag leaves it unchanged.
// - Mask bits 6 and 5 gate slot events, 0 enables, reset to 1.
module sbr_regs
	import sbr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	input wire logic [7:0] buffer_byte_count_in,
	input wire logic buffer_access_enable_in,
	output logic buffer_clear_out,
	input wire logic second_slot_event_in,
	input wire logic first_slot_event_in,
	output logic second_slot_event_pending_out,
	output logic first_slot_event_pending_out,
	output logic [15:0] second_slot_frontend_mode_out,
	output logic [3:0] second_slot_ch_gain_out [4],
	output logic [1:0] second_slot_route_out
);
	logic [15:0] mode_r;
	logic [15:0] gain_r;
	logic [15:0] routing_r;
	logic [15:0] mask_r;
	logic [15:0] chgain_r;
	logic status_spare_r;
	logic [4:0] status_rsvd_r;
	logic second_slot_event_flag_r;
	logic first_slot_event_flag_r;
	logic buffer_clear_r;

	// Maps a two-bit code to a one-hot gain selection.
	function automatic logic [3:0] gain_decode(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

	// Address decode strobes.
	wire wr_status = reg_wr_in && (reg_addr_in == `SBR_ADDR_STATUS);
	wire wr_mask = reg_wr_in && (reg_addr_in == `SBR_ADDR_MASK);
	wire wr_mode = reg_wr_in && (reg_addr_in == `SBR_ADDR_MODE);
	wire wr_gain = reg_wr_in && (reg_addr_in == `SBR_ADDR_GAIN);
	wire wr_routing = reg_wr_in && (reg_addr_in == `SBR_ADDR_ROUTING);
	wire wr_chgain = reg_wr_in && (reg_addr_in == `SBR_ADDR_CHGAIN);
	wire second_slot_per_channel_gain_enable = gain_r[`SBR_BIT_IND_EN];
	wire [1:0] second_slot_gain_code = gain_r[1:0];

	// Flag next values: set wins over a simultaneous clear.
	// write one clears
	wire b_flag_nxt = second_slot_event_in
		|| (second_slot_event_flag_r && !(wr_status && reg_wdata_in[`SBR_BIT_B_FLAG]));
	wire a_flag_nxt = first_slot_event_in
		|| (first_slot_event_flag_r && !(wr_status && reg_wdata_in[`SBR_BIT_A_FLAG]));

	// Configuration registers with reset defaults.
	// defaults and reserved retention
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			mode_r <= `SBR_RST_MODE;
			gain_r <= `SBR_RST_GAIN;
			routing_r <= `SBR_RST_ROUTING;
			mask_r <= `SBR_RST_MASK;
			chgain_r <= `SBR_RST_CHGAIN;
		end
		else
		begin
			if (wr_mode) mode_r <= reg_wdata_in;
			if (wr_gain) gain_r <= reg_wdata_in;
			if (wr_routing) routing_r <= reg_wdata_in;
			if (wr_mask) mask_r <= reg_wdata_in;
			if (wr_chgain) chgain_r <= reg_wdata_in;
		end
	end

	// Status flags, reserved status bits and the FIFO clear pulse.
	// event sets flag
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			second_slot_event_flag_r <= 1'b0;
			first_slot_event_flag_r <= 1'b0;
			status_rsvd_r <= 5'h00;
			status_spare_r <= 1'b0;
			buffer_clear_r <= 1'b0;
		end
		else
		begin
			second_slot_event_flag_r <= b_flag_nxt;
			first_slot_event_flag_r <= a_flag_nxt;
			buffer_clear_r <= wr_status && reg_wdata_in[`SBR_BIT_CLEAR] && buffer_access_enable_in;
			if (wr_status)
			begin
				status_rsvd_r <= reg_wdata_in[4:0];
				status_spare_r <= reg_wdata_in[`SBR_BIT_SPARE];
			end
		end
	end

	// Per-channel gain selection.
	// per-channel override
	assign second_slot_ch_gain_out[0] = gain_decode(second_slot_gain_code);
	assign second_slot_ch_gain_out[1] = gain_decode(second_slot_per_channel_gain_enable
		? chgain_r[7:6] : second_slot_gain_code);
	assign second_slot_ch_gain_out[2] = gain_decode(second_slot_per_channel_gain_enable
		? chgain_r[9:8] : second_slot_gain_code);
	assign second_slot_ch_gain_out[3] = gain_decode(second_slot_per_channel_gain_enable
		? chgain_r[11:10] : second_slot_gain_code);

	// Routing decode; reserved words report as reserved.
	// routing modes
	assign second_slot_route_out = (routing_r == `SBR_ROUTE_FULL) ? SBR_ROUTE_FULL_PATH :
		(routing_r == `SBR_ROUTE_TIA_ADC) ? SBR_ROUTE_TIA_CONV : SBR_ROUTE_RSVD;

	// Masked pending events; a mask bit of zero enables.
	// mask gating
	assign second_slot_event_pending_out = second_slot_event_flag_r && !mask_r[`SBR_BIT_B_MASK];
	assign first_slot_event_pending_out = first_slot_event_flag_r && !mask_r[`SBR_BIT_A_MASK];
	assign second_slot_frontend_mode_out = mode_r;
	assign buffer_clear_out = buffer_clear_r;

	// Read multiplexer; unmapped addresses read zero.
	// byte count readback
	always_comb
	begin
		unique case (reg_addr_in)
			`SBR_ADDR_STATUS: reg_rdata_out = {buffer_byte_count_in, status_spare_r,
				second_slot_event_flag_r, first_slot_event_flag_r, status_rsvd_r};
			`SBR_ADDR_MASK: reg_rdata_out = mask_r;
			`SBR_ADDR_MODE: reg_rdata_out = mode_r;
			`SBR_ADDR_GAIN: reg_rdata_out = gain_r;
			`SBR_ADDR_ROUTING: reg_rdata_out = routing_r;
			`SBR_ADDR_CHGAIN: reg_rdata_out = chgain_r;
			default: reg_rdata_out = 16'h0000;
		endcase
	end

	// Assertions.
	property p_clear_b;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(wr_status && reg_wdata_in[6] && !second_slot_event_in) |=> !second_slot_event_flag_r;
	endproperty
	a_clear_b: assert property (p_clear_b) else $error("slot B flag not cleared");
	property p_keep_b;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(second_slot_event_flag_r && !(wr_status && reg_wdata_in[6])) |=> second_slot_event_flag_r;
	endproperty
	a_keep_b: assert property (p_keep_b) else $error("slot B flag lost");
	property p_set_a;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		first_slot_event_in |=> first_slot_event_flag_r;
	endproperty
	a_set_a: assert property (p_set_a) else $error("slot A flag not set");
	property p_fifo_clr;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(wr_status && reg_wdata_in[15]) |=> (buffer_clear_out == $past(buffer_access_enable_in));
	endproperty
	a_fifo_clr: assert property (p_fifo_clr) else $error("FIFO clear wrong");
	property p_common_gain;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		!gain_r[6] |-> (second_slot_ch_gain_out[3] == second_slot_ch_gain_out[0]);
	endproperty
	a_common_gain: assert property (p_common_gain) else $error("channel gains differ");
	property p_ind_gain;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		gain_r[6] |-> (second_slot_ch_gain_out[3] == (4'h1 << chgain_r[11:10]));
	endproperty
	a_ind_gain: assert property (p_ind_gain) else $error("ch4 gain wrong");
	property p_count;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(reg_addr_in == 8'h00) |-> (reg_rdata_out[15:8] == buffer_byte_count_in);
	endproperty
	a_count: assert property (p_count) else $error("byte count wrong");
	property p_mask;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		mask_r[6] |-> !second_slot_event_pending_out;
	endproperty
	a_mask: assert property (p_mask) else $error("masked event pending");
	property p_set_b;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		second_slot_event_in |=> second_slot_event_flag_r;
	endproperty
	a_set_b: assert property (p_set_b) else $error("slot B flag not set");
	property p_clear_a;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(wr_status && reg_wdata_in[`SBR_BIT_A_FLAG] && !first_slot_event_in) |=> !first_slot_event_flag_r;
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("slot A flag not cleared");
	property p_keep_a;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(first_slot_event_flag_r && !(wr_status && reg_wdata_in[`SBR_BIT_A_FLAG])) |=> first_slot_event_flag_r;
	endproperty
	a_keep_a: assert property (p_keep_a) else $error("slot A flag lost");
	property p_mask_a;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		mask_r[`SBR_BIT_A_MASK] |-> !first_slot_event_pending_out;
	endproperty
	a_mask_a: assert property (p_mask_a) else $error("masked slot A event pending");
	property p_clr_cause;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		buffer_clear_out |-> ($past(wr_status) && $past(reg_wdata_in[`SBR_BIT_CLEAR]) && $past(buffer_access_enable_in));
	endproperty
	a_clr_cause: assert property (p_clr_cause) else $error("FIFO clear without request");
	property p_route_tia;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		(routing_r == `SBR_ROUTE_TIA_ADC) |-> (second_slot_route_out == SBR_ROUTE_TIA_CONV);
	endproperty
	a_route_tia: assert property (p_route_tia) else $error("routing mode wrong");
	property p_ch1_gain;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		gain_r[`SBR_BIT_IND_EN] |-> (second_slot_ch_gain_out[0] == (4'h1 << gain_r[1:0]));
	endproperty
	a_ch1_gain: assert property (p_ch1_gain) else $error("ch1 gain wrong");
endmodule

// *** tb/sbr_host.sv ***
`timescale 1ns/1ps
module sbr_host
(
	input wire logic core_clk_in,
	input wire logic [15:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic [15:0] reg_wdata_out
);
	// The bus starts idle.
	initial
	begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 16'h0000;
	end
	// whole word writes
	// A write holds for one edge, then the data lines flip so nothing stale remains.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		reg_addr_out <= a;
		reg_wr_out <= 1'b1;
		reg_wdata_out <= d;
		@(posedge core_clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	// A read samples the settled data at the falling edge.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk_in);
		reg_addr_out <= a;
		@(negedge core_clk_in);
		d = reg_rdata_in;
	endtask
endmodule

// *** tb/tb_sbr_regs.sv ***
`timescale 1ns/1ps
module tb_sbr_regs;
	logic core_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] bus_addr;
	logic bus_wr;
	logic [15:0] bus_wdata;
	logic [15:0] rdata;
	logic [7:0] count = 8'h00;
	logic acc_en = 1'b0;
	logic ev_b = 1'b0;
	logic ev_a = 1'b0;
	logic clr;
	logic pend_b;
	logic pend_a;
	logic [15:0] mode;
	logic [3:0] gain [4];
	logic [1:0] route;
	logic [15:0] v;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Clock of 25 ns period.
	always #12.5 core_clk_in = ~core_clk_in;
	sbr_regs i_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(bus_addr),
		.reg_wr_in(bus_wr), .reg_wdata_in(bus_wdata), .reg_rdata_out(rdata), .buffer_byte_count_in(count),
		.buffer_access_enable_in(acc_en), .buffer_clear_out(clr), .second_slot_event_in(ev_b),
		.first_slot_event_in(ev_a), .second_slot_event_pending_out(pend_b),
		.first_slot_event_pending_out(pend_a), .second_slot_frontend_mode_out(mode),
		.second_slot_ch_gain_out(gain), .second_slot_route_out(route));
	sbr_host i_host (.core_clk_in(core_clk_in), .reg_rdata_in(rdata), .reg_addr_out(bus_addr),
		.reg_wr_out(bus_wr), .reg_wdata_out(bus_wdata));
	// Compares a seen value with its expectation.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Checks the four one-hot channel gains against codes.
	task automatic gains(input logic [1:0] c0, input logic [1:0] c1, input logic [1:0] c2, input logic [1:0] c3);
		chk(16'(gain[0]), 16'h0001 << c0);
		chk(16'(gain[1]), 16'h0001 << c1);
		chk(16'(gain[2]), 16'h0001 << c2);
		chk(16'(gain[3]), 16'h0001 << c3);
	endtask
	// Reset values and the gain decode with and without override.
	task automatic t_cfg();
		#1 chk(mode, 16'h22FC);
		chk(16'(route), 16'h0001);
		gains(2'h0, 2'h0, 2'h0, 2'h0);
		i_host.rd(8'h01, v);
		chk(v, 16'h00FF);
		i_host.rd(8'h44, v);
		chk(v, 16'h1C38);
		i_host.rd(8'h45, v);
		chk(v, 16'hADA5);
		i_host.rd(8'h00, v);
		chk(v, 16'h0000);
		for (int c = 0; c < 4; c++)
		begin
			i_host.wr(8'h44, 16'h1C38 | 16'(c));
			#1 gains(2'(c), 2'(c), 2'(c), 2'(c));
		end
		i_host.wr(8'h55, 16'h0E40);
		i_host.wr(8'h44, 16'h1C79);
		#1 gains(2'h1, 2'h1, 2'h2, 2'h3);
		i_host.rd(8'h44, v);
		chk(v, 16'h1C79);
		i_host.wr(8'h3B, 16'h21F4);
		#1 chk(mode, 16'h21F4);
		i_host.wr(8'h45, 16'hB065);
		#1 chk(16'(route), 16'h0002);
		i_host.wr(8'h45, 16'h1234);
		#1 chk(16'(route), 16'h0000);
	endtask
	// Byte count, event flags, masks and the buffer clear.
	task automatic t_status();
		@(posedge core_clk_in);
		count <= 8'hA5;
		ev_b <= 1'b1;
		@(posedge core_clk_in);
		ev_b <= 1'b0;
		#1 chk(16'(pend_b), 16'h0000);
		i_host.rd(8'h00, v);
		chk(v, 16'hA540);
		chk(16'(v[15:9]), 16'h0052);
		i_host.wr(8'h01, 16'h0000);
		#1 chk(16'(pend_b), 16'h0001);
		i_host.wr(8'h00, 16'h0020);
		i_host.rd(8'h00, v);
		chk(v, 16'hA540);
		i_host.wr(8'h00, 16'h0040);
		i_host.rd(8'h00, v);
		chk(v, 16'hA500);
		@(posedge core_clk_in);
		ev_a <= 1'b1;
		@(posedge core_clk_in);
		ev_a <= 1'b0;
		#1 chk(16'(pend_a), 16'h0001);
		i_host.wr(8'h00, 16'h8000);
		#1 chk(16'(clr), 16'h0000);
		@(posedge core_clk_in);
		acc_en <= 1'b1;
		i_host.wr(8'h00, 16'h8000);
		#1 chk(16'(clr), 16'h0001);
		@(posedge core_clk_in);
		#1 chk(16'(clr), 16'h0000);
	endtask
	// A second reset in mid-run brings every register back to its default.
	task automatic t_reset();
		@(posedge core_clk_in);
		arst_n_in <= 1'b0;
		@(posedge core_clk_in);
		#1 chk(mode, 16'h22FC);
		chk(16'(route), 16'h0001);
		chk(16'({pend_b, pend_a, clr}), 16'h0000);
		gains(2'h0, 2'h0, 2'h0, 2'h0);
		@(posedge core_clk_in);
		arst_n_in <= 1'b1;
		i_host.rd(8'h00, v);
		chk(v, 16'hA500);
		i_host.rd(8'h01, v);
		chk(v, 16'h00FF);
		i_host.rd(8'h44, v);
		chk(v, 16'h1C38);
	endtask
	// Cuts a hang short.
	always @(posedge core_clk_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_count++;
			final_report();
		end
	end
	// Main sequence.
	initial
	begin
		repeat (12) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		t_cfg();
		t_status();
		t_reset();
		final_report();
	end
endmodule
